// ### verilog/sbpc_pkg.sv
// Package for the bus phase control block: offsets, fields, reset values, types.
// Assumes a 32-bit classic Wishbone slave with byte-wide, word-aligned registers.
`default_nettype none
package sbpc_pkg;
    // ********************************
    // Register indices and addresses
    // ********************************
    localparam logic [7:0] SBPC_IDX_ID_IN = 8'h41;
    localparam logic [7:0] SBPC_IDX_PHASE = 8'h42;
    localparam logic [7:0] SBPC_IDX_OPCTL = 8'h45;
    localparam logic [7:0] SBPC_IDX_STAT2 = 8'h48;
    localparam logic [7:0] SBPC_IDX_BUSIN = 8'h4c;
    localparam int SBPC_ADDR_W = 10;
    // ********************************
    // Phase control fields
    // ********************************
    localparam int SBPC_PH_CD = 0;
    localparam int SBPC_PH_IO = 1;
    localparam int SBPC_PH_MSG = 2;
    localparam int SBPC_PH_REQ = 3;
    localparam int SBPC_PH_BSY = 4;
    localparam int SBPC_PH_SEL = 5;
    localparam int SBPC_PH_ATN = 6;
    localparam int SBPC_PH_ACK = 7;
    // ********************************
    // Operation control fields
    // ********************************
    localparam int SBPC_OP_AUTO = 1;
    localparam int SBPC_OP_DOE = 3;
    localparam int SBPC_OP_TGT = 4;
    localparam int SBPC_OP_INI = 5;
    localparam int SBPC_OP_RST = 7;
    // ********************************
    // Status two fields
    // ********************************
    localparam int SBPC_ST_SELD = 0;
    localparam int SBPC_ST_RESELD = 1;
    localparam int SBPC_ST_MISM = 6;
    localparam logic [7:0] SBPC_RST_BYTE = 8'h00;
    // ********************************
    // Phase codes as msg, cd, io
    // ********************************
    typedef enum logic [2:0] {
        SBPC_DATA_OUT = 3'h0,
        SBPC_DATA_IN = 3'h1,
        SBPC_COMMAND = 3'h2,
        SBPC_STATUS = 3'h3,
        SBPC_UNDEF_4 = 3'h4,
        SBPC_UNDEF_5 = 3'h5,
        SBPC_MSG_OUT = 3'h6,
        SBPC_MSG_IN = 3'h7
    } sbpc_phase_t;
    typedef enum logic [1:0] {
        SBPC_ST_IDLE = 2'b01,
        SBPC_ST_HOLD = 2'b10
    } sbpc_resp_t;
    // Bus control lines, one bit each, polarity set by the port: active low on bus_ctl_n_i
    typedef struct packed {
        logic rst;
        logic atn;
        logic ack;
        logic sel;
        logic bsy;
        logic req;
        logic msg;
        logic cd;
        logic io;
    } sbpc_ctl_t;
endpackage
`default_nettype wire

// ### verilog/sbpc_top.sv
// Bus phase control: reselection detect, role gating, phase compare, Wishbone regs.
// Assumes synchronous bus inputs (active-low levels) and a classic Wishbone master.
// Contract
// [R1] Reselection sets reselected status flag
// [R2] Reselection sets initiator enable, holds busy
// [R3] Reselection latches data bus into ID
// [R4] Firmware control lines qualified by role bits
// [R5] Target lines driven only with target enable
// [R6] Initiator lines driven only with initiator enable
// [R7] Busy and select never role gated
// [R8] Firmware busy plus automatic busy both allowed
// [R9] Firmware sets data enable before roles
// [R10] Reset-out bit drives reset line at once
// [R11] Phase lines driven only after target enable
// [R12] Phase bits read as inverse bus levels
// [R13] Bit zero: control when one
// [R14] Bit one: into initiator when one
// [R15] Bit two: message when one
// [R16] Phase encoding table msg/cd/io
// [R17] Initiator never drives phase lines
// [R18] Firmware sets attention for message out
// [R19] Firmware writes predicted phase as initiator
// [R20] Request leading edge compare sets mismatch
// [R21] Mismatch blocks transfer and signals status
// [R22] Auto detection only with auto enable
// [R23] Reset clears roles, data enable, reset-out
//
// Limitation: phase codes 100 and 101 are passed through undecoded.
// Limitation: mismatch holds off ack until software reads status.
`default_nettype none
module sbpc_top #(
    parameter int OWN_ID_BIT = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sbpc_pkg::SBPC_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] bus_data_n_i,
    input wire sbpc_pkg::sbpc_ctl_t bus_ctl_n_i,
    input wire logic [7:0] id_out_i,
    input wire logic arb_bsy_i,
    output logic [7:0] bus_data_n_o,
    output logic bus_data_oe_o,
    output sbpc_pkg::sbpc_ctl_t bus_ctl_n_o,
    output sbpc_pkg::sbpc_ctl_t bus_ctl_oe_o,
    output logic xfer_block_o,
    output logic mismatch_o
);
    // ********************************
    // Bus slave
    // ********************************
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [7:0] phase_ff;
    logic [7:0] opctl_ff;
    logic [7:0] stat2_ff;
    logic [7:0] id_in_ff;
    logic req_seen_ff;
    sbpc_pkg::sbpc_resp_t resp_ff;
    sbpc_pkg::sbpc_resp_t nxt_resp;
    logic req_n;
    logic wr;
    logic [7:0] idx;
    logic [7:0] bus_level;
    logic resel_det;
    logic sel_det;
    logic req_lead;
    logic [2:0] bus_phase;
    logic [7:0] phase_view;
    logic tgt_en;
    logic ini_en;

    function automatic logic [7:0] sbpc_word_idx(input logic [sbpc_pkg::SBPC_ADDR_W-1:0] a);
        sbpc_word_idx = a[9:2];
    endfunction

    // Bus order msg,cd,io to register order msg,io,cd
    // Register keeps cd in bit 0, so the two orders differ [R16]
    function automatic logic [2:0] sbpc_reg_order(input logic [2:0] mci);
        sbpc_reg_order = {mci[2], mci[0], mci[1]};
    endfunction

    // Role gate: a line is pulled only with its enable and request bit
    function automatic logic sbpc_gate(input logic en, input logic want);
        sbpc_gate = en && want;
    endfunction

    assign req_n = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = req_n && wb_we_i && wb_sel_i[0];
    assign idx = sbpc_word_idx(wb_adr_i);
    // Bus is active low; register view is the complement
    assign bus_level = ~bus_data_n_i;
    // Phase as msg,cd,io from the bus, inverted [R12] [R16]
    assign bus_phase = {!bus_ctl_n_i.msg, !bus_ctl_n_i.cd, !bus_ctl_n_i.io};
    // Reselection: select and io asserted, busy free, own ID on data [R22]
    assign resel_det = opctl_ff[sbpc_pkg::SBPC_OP_AUTO] && !bus_ctl_n_i.sel && !bus_ctl_n_i.io
        && bus_ctl_n_i.bsy && bus_level[OWN_ID_BIT] && resp_ff == sbpc_pkg::SBPC_ST_IDLE;
    assign sel_det = opctl_ff[sbpc_pkg::SBPC_OP_AUTO] && !bus_ctl_n_i.sel && bus_ctl_n_i.io
        && bus_ctl_n_i.bsy && bus_level[OWN_ID_BIT] && resp_ff == sbpc_pkg::SBPC_ST_IDLE;
    // Leading edge of request while initiator [R20]
    assign req_lead = opctl_ff[sbpc_pkg::SBPC_OP_INI] && !bus_ctl_n_i.req && !req_seen_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_n;
        end
    end

    // Unmapped addresses read as zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (req_n) begin
            case (idx)
                sbpc_pkg::SBPC_IDX_ID_IN: rdata_ff <= {24'h00_0000, id_in_ff};
                sbpc_pkg::SBPC_IDX_PHASE: rdata_ff <= {24'h00_0000, phase_view};
                sbpc_pkg::SBPC_IDX_OPCTL: rdata_ff <= {24'h00_0000, opctl_ff};
                sbpc_pkg::SBPC_IDX_STAT2: rdata_ff <= {24'h00_0000, stat2_ff};
                sbpc_pkg::SBPC_IDX_BUSIN: rdata_ff <= {24'h00_0000, bus_level};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Read view: phase bits show bus levels in either role [R12]
    always_comb begin
        phase_view = phase_ff;
        phase_view[sbpc_pkg::SBPC_PH_CD] = bus_phase[1]; // [R13]
        phase_view[sbpc_pkg::SBPC_PH_IO] = bus_phase[0]; // [R14]
        phase_view[sbpc_pkg::SBPC_PH_MSG] = bus_phase[2]; // [R15]
        phase_view[sbpc_pkg::SBPC_PH_REQ] = !bus_ctl_n_i.req;
        phase_view[sbpc_pkg::SBPC_PH_ACK] = !bus_ctl_n_i.ack;
    end

    // ********************************
    // Selection response sequencer
    // ********************************
    always_comb begin
        nxt_resp = resp_ff;
        case (resp_ff)
            sbpc_pkg::SBPC_ST_IDLE: begin
                if (resel_det || sel_det) begin
                    nxt_resp = sbpc_pkg::SBPC_ST_HOLD;
                end
            end
            sbpc_pkg::SBPC_ST_HOLD: begin
                // Busy held until select seen released or auto enable cleared
                if (bus_ctl_n_i.sel || !opctl_ff[sbpc_pkg::SBPC_OP_AUTO]) begin
                    nxt_resp = sbpc_pkg::SBPC_ST_IDLE;
                end
            end
            default: nxt_resp = sbpc_pkg::SBPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_ff <= sbpc_pkg::SBPC_ST_IDLE;
        end else begin
            resp_ff <= nxt_resp;
        end
    end

    // ********************************
    // Control registers
    // ********************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opctl_ff <= sbpc_pkg::SBPC_RST_BYTE; // [R23]
        end else begin
            if (wr && idx == sbpc_pkg::SBPC_IDX_OPCTL) begin
                opctl_ff <= wb_dat_i[7:0]; // [R9] [R10]
            end
            // Hardware set wins over a same-cycle write
            if (resel_det) begin
                opctl_ff[sbpc_pkg::SBPC_OP_INI] <= 1'b1; // [R2]
            end
            if (sel_det) begin
                opctl_ff[sbpc_pkg::SBPC_OP_TGT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= sbpc_pkg::SBPC_RST_BYTE;
        end else begin
            if (wr && idx == sbpc_pkg::SBPC_IDX_PHASE) begin
                phase_ff <= wb_dat_i[7:0]; // [R19] [R18]
            end
            if (resel_det || sel_det) begin
                phase_ff[sbpc_pkg::SBPC_PH_BSY] <= 1'b1; // [R2]
            end else if (resp_ff == sbpc_pkg::SBPC_ST_HOLD && nxt_resp == sbpc_pkg::SBPC_ST_IDLE) begin
                phase_ff[sbpc_pkg::SBPC_PH_BSY] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            id_in_ff <= sbpc_pkg::SBPC_RST_BYTE;
        end else if (resel_det || sel_det) begin
            id_in_ff <= bus_level; // [R3]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_seen_ff <= 1'b0;
        end else begin
            req_seen_ff <= !bus_ctl_n_i.req;
        end
    end

    // Status flags: read clears, but a new event in that cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat2_ff <= sbpc_pkg::SBPC_RST_BYTE;
        end else begin
            if (req_n && !wb_we_i && idx == sbpc_pkg::SBPC_IDX_STAT2) begin
                stat2_ff <= sbpc_pkg::SBPC_RST_BYTE;
            end
            if (resel_det) begin
                stat2_ff[sbpc_pkg::SBPC_ST_RESELD] <= 1'b1; // [R1]
            end
            if (sel_det) begin
                stat2_ff[sbpc_pkg::SBPC_ST_SELD] <= 1'b1;
            end
            if (req_lead && sbpc_reg_order(bus_phase) != phase_ff[2:0]) begin
                stat2_ff[sbpc_pkg::SBPC_ST_MISM] <= 1'b1; // [R20]
            end
        end
    end

    // ********************************
    // Bus drivers
    // ********************************
    // Role enables, shared by every gated line below [R4]
    always_comb begin
        tgt_en = opctl_ff[sbpc_pkg::SBPC_OP_TGT];
        ini_en = opctl_ff[sbpc_pkg::SBPC_OP_INI];
    end

    // Line enables: high pulls that line low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_ctl_oe_o <= '0; // [R23]
        end else begin
            // Target lines gated by target enable [R5] [R11]
            // Initiator never drives phase lines [R17]
            bus_ctl_oe_o.msg <= sbpc_gate(
                tgt_en,
                phase_ff[sbpc_pkg::SBPC_PH_MSG]
            );
            bus_ctl_oe_o.cd <= sbpc_gate(
                tgt_en,
                phase_ff[sbpc_pkg::SBPC_PH_CD]
            );
            bus_ctl_oe_o.io <= sbpc_gate(
                tgt_en,
                phase_ff[sbpc_pkg::SBPC_PH_IO]
            );
            bus_ctl_oe_o.req <= sbpc_gate(
                tgt_en,
                phase_ff[sbpc_pkg::SBPC_PH_REQ]
            );
            // Initiator lines gated by initiator enable [R6]
            bus_ctl_oe_o.atn <= sbpc_gate(
                ini_en,
                phase_ff[sbpc_pkg::SBPC_PH_ATN]
            );
            // Ack withheld while a mismatch stands, so no byte moves [R21]
            bus_ctl_oe_o.ack <= sbpc_gate(
                ini_en,
                phase_ff[sbpc_pkg::SBPC_PH_ACK] && !stat2_ff[sbpc_pkg::SBPC_ST_MISM]
            );
            // Busy free of role bits; arbitration may also assert it [R7] [R8]
            bus_ctl_oe_o.bsy <= phase_ff[sbpc_pkg::SBPC_PH_BSY]
                || arb_bsy_i
                || resp_ff == sbpc_pkg::SBPC_ST_HOLD; // [R2]
            // Select free of role bits [R7]
            bus_ctl_oe_o.sel <= phase_ff[sbpc_pkg::SBPC_PH_SEL];
            // Reset-out ignores phase and roles [R10]
            bus_ctl_oe_o.rst <= opctl_ff[sbpc_pkg::SBPC_OP_RST];
        end
    end

    // Open-drain style: level is low, the enable decides
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_ctl_n_o <= '1;
        end else begin
            bus_ctl_n_o <= '0;
        end
    end

    // ID drive needs data enable plus a role bit [R9]
    // Not limited to selection phases; software owns the timing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_data_oe_o <= 1'b0; // [R23]
        end else begin
            bus_data_oe_o <= opctl_ff[sbpc_pkg::SBPC_OP_DOE]
                && (tgt_en || ini_en);
        end
    end

    // Data level is the inverse of the ID byte, active-low bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_data_n_o <= 8'hff;
        end else begin
            bus_data_n_o <= ~id_out_i;
        end
    end

    // ********************************
    // Status outputs
    // ********************************
    // Block tracks the mismatch flag until software clears it [R21]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xfer_block_o <= 1'b0;
        end else begin
            xfer_block_o <= stat2_ff[sbpc_pkg::SBPC_ST_MISM]; // [R21]
        end
    end

    // Mismatch seen outside without a register read [R20]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mismatch_o <= 1'b0;
        end else begin
            mismatch_o <= stat2_ff[sbpc_pkg::SBPC_ST_MISM];
        end
    end

    // ********************************
    // Bus slave outputs
    // ********************************
    // Both straight from flip-flops
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

endmodule
`default_nettype wire

// ### dv/sbpc_assertions.sv
// Checker for the bus phase control block, bound to its top.
// Assumes one clock, synchronous active-high reset, registered outputs.
`default_nettype none
module sbpc_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sbpc_pkg::SBPC_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] id_out_i,
    input wire logic [7:0] bus_data_n_o,
    input wire logic bus_data_oe_o,
    input wire sbpc_pkg::sbpc_ctl_t bus_ctl_n_o,
    input wire sbpc_pkg::sbpc_ctl_t bus_ctl_oe_o,
    input wire logic xfer_block_o,
    input wire logic mismatch_o
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence wr_s(logic [7:0] idx);
        take_s ##0 wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == idx;
    endsequence
    // Outputs lag the write by a cycle, so allow two edges
    ack_resp_a: assert property (take_s |=> wb_ack_o) else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    rst_out_a: assert property (wr_s(sbpc_pkg::SBPC_IDX_OPCTL) ##0 wb_dat_i[7] |-> ##[1:2] bus_ctl_oe_o.rst)
        else $error("reset line not driven");
    sel_drive_a: assert property (wr_s(sbpc_pkg::SBPC_IDX_PHASE) ##0 wb_dat_i[5] |-> ##[1:2] bus_ctl_oe_o.sel)
        else $error("select not driven");
    data_id_a: assert property (bus_data_oe_o |-> bus_data_n_o == ~$past(id_out_i))
        else $error("data bus not the id byte");
    ack_block_a: assert property (mismatch_o && $past(mismatch_o) |-> !bus_ctl_oe_o.ack)
        else $error("ack driven during mismatch");
    block_flag_a: assert property (xfer_block_o == mismatch_o) else $error("block differs from mismatch");
    reset_quiet_a: assert property ($past(rst_i) |-> bus_ctl_oe_o == '0 && !bus_data_oe_o)
        else $error("lines driven after reset");
    lines_low_a: assert property (!$past(rst_i) |-> bus_ctl_n_o == '0) else $error("driven level not low");
endmodule
bind sbpc_top sbpc_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .id_out_i, .bus_data_n_o, .bus_data_oe_o, .bus_ctl_n_o, .bus_ctl_oe_o, .xfer_block_o,
    .mismatch_o);
`default_nettype wire

// ### dv/sbpc_far_model.sv
// Far-side bus device: reselects, sets phases, raises request.
// Assumes terminated lines: a released line reads deasserted.
`default_nettype none
module sbpc_far_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic resel_i,
    input wire logic req_i,
    input wire logic [2:0] phase_i,
    input wire logic [7:0] id_i,
    input wire sbpc_pkg::sbpc_ctl_t bus_n_i,
    output sbpc_pkg::sbpc_ctl_t drv_o,
    output logic [7:0] data_o
);
    // ****************
    // Behaviour
    // ****************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_o <= '0;
            data_o <= 8'h00;
        end else begin
            drv_o <= '0;
            data_o <= resel_i ? id_i : 8'h00;
            drv_o.sel <= resel_i;
            drv_o.req <= req_i;
            {drv_o.msg, drv_o.cd, drv_o.io} <= phase_i | {2'b00, resel_i};
            if (!bus_n_i.atn) begin
                {drv_o.msg, drv_o.cd, drv_o.io} <= sbpc_pkg::SBPC_MSG_OUT;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/sbpc_tb.sv
// Self-checking bench for the bus phase control block.
// Assumes the far-side model and the bound checker are compiled first.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Bench
    // ****************
    logic clk_i, rst_i, cs, we, ack, data_oe, mism, blk, resel, req, arb, t, i, doe, x;
    logic [9:0] adr;
    logic [31:0] dat, rdat, r;
    logic [7:0] id, fdat, data_n_o, data_n, q, ph;
    logic [2:0] fph, pc;
    sbpc_pkg::sbpc_ctl_t oe, ctl_n_o, fctl, ctl_n;
    int n_fail, checks_done, seed, k, n;
    assign ctl_n = sbpc_pkg::sbpc_ctl_t'(~(oe | fctl));
    assign data_n = ~((data_oe ? ~data_n_o : 8'h00) | fdat);
    sbpc_top DUT (.clk_i, .rst_i, .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .bus_data_n_i(data_n), .bus_ctl_n_i(ctl_n), .id_out_i(id),
        .arb_bsy_i(arb), .bus_data_n_o(data_n_o), .bus_data_oe_o(data_oe), .bus_ctl_n_o(ctl_n_o),
        .bus_ctl_oe_o(oe), .xfer_block_o(blk), .mismatch_o(mism));
    sbpc_far_model far (.clk_i, .rst_i, .resel_i(resel), .req_i(req), .phase_i(fph), .id_i(8'h21), .bus_n_i(ctl_n),
        .drv_o(fctl), .data_o(fdat));
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        n = 0;
        @(posedge clk_i);
        cs <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
        if (n >= 50) n_fail++;
        q = rdat[7:0];
        cs <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic sbpc_pkg::sbpc_ctl_t exp_oe(input logic [7:0] p, input logic tg, input logic in);
        sbpc_pkg::sbpc_ctl_t e;
        e = '0;
        {e.msg, e.io, e.cd, e.req} = {p[2:0], p[3]} & {4{tg}};
        {e.ack, e.atn} = p[7:6] & {2{in}};
        {e.sel, e.bsy} = p[5:4];
        return e;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Generous bound: the sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        conclude();
    end
    initial begin
        {rst_i, cs, we, adr, dat, id, resel, req, arb, fph, seed} = {1'b1, 58'h0, 32'd81};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({oe, data_oe}, 0);
        wb(0, sbpc_pkg::SBPC_IDX_OPCTL, 0);
        chk(q, 0);
        wb(0, 8'h10, 0);
        chk(q, 0);
        $display("test reset done");
        for (k = 0; k < 12; k++) begin
            r = $random(seed);
            {doe, i, t, ph} = {r[10:8] & 3'b101 | {1'b0, r[9] & !r[8], 1'b0}, r[7:0]};
            id <= r[23:16];
            wb(1, sbpc_pkg::SBPC_IDX_PHASE, 0);
            wb(1, sbpc_pkg::SBPC_IDX_OPCTL, {4'h0, doe, 3'b000});
            wb(1, sbpc_pkg::SBPC_IDX_OPCTL, {2'b00, i, t, doe, 3'b000});
            wb(1, sbpc_pkg::SBPC_IDX_PHASE, ph);
            repeat (4) @(posedge clk_i);
            chk(oe, exp_oe(ph, t, i));
            chk({data_oe, data_n_o}, {doe & (t | i), ~id});
            wb(0, sbpc_pkg::SBPC_IDX_PHASE, 0);
            chk(q, {i & ph[7], ph[6:4], t & ph[3], t ? ph[2:0] : {i & ph[6], 1'b0, i & ph[6]}});
        end
        arb <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(oe.bsy, 1);
        arb <= 1'b0;
        $display("test roles done");
        wb(1, sbpc_pkg::SBPC_IDX_PHASE, 0);
        wb(1, sbpc_pkg::SBPC_IDX_OPCTL, 8'h20);
        for (k = 0; k < 16; k++) begin
            r = $random(seed);
            pc = k[2:0];
            fph <= (k < 8) ? pc : r[2:0];
            x = (k >= 8) && (r[2:0] != pc);
            wb(1, sbpc_pkg::SBPC_IDX_PHASE, {5'h10, pc[2], pc[0], pc[1]});
            repeat (2) @(posedge clk_i);
            req <= 1'b1;
            repeat (4) @(posedge clk_i);
            chk({mism, blk, oe.ack}, {x, x, !x});
            chk({oe.msg, oe.cd, oe.io}, 0);
            req <= 1'b0;
            wb(0, sbpc_pkg::SBPC_IDX_STAT2, 0);
            chk(q, {1'b0, x, 6'h00});
        end
        fph <= 3'h0;
        wb(1, sbpc_pkg::SBPC_IDX_PHASE, 8'h40);
        repeat (4) @(posedge clk_i);
        wb(0, sbpc_pkg::SBPC_IDX_PHASE, 0);
        chk(q, 8'h45);
        wb(1, sbpc_pkg::SBPC_IDX_PHASE, 0);
        $display("test phase done");
        for (k = 0; k < 2; k++) begin
            wb(1, sbpc_pkg::SBPC_IDX_OPCTL, {6'h00, k[0], 1'b0});
            resel <= 1'b1;
            repeat (5) @(posedge clk_i);
            chk(oe.bsy, k[0]);
            resel <= 1'b0;
            repeat (5) @(posedge clk_i);
            chk(oe.bsy, 0);
            wb(0, sbpc_pkg::SBPC_IDX_STAT2, 0);
            chk(q, {6'h00, k[0], 1'b0});
            wb(0, sbpc_pkg::SBPC_IDX_OPCTL, 0);
            chk(q, {2'b00, k[0], 3'b000, k[0], 1'b0});
            wb(0, sbpc_pkg::SBPC_IDX_ID_IN, 0);
            chk(q, 8'h21 & {8{k[0]}});
        end
        $display("test reselection done");
        wb(1, sbpc_pkg::SBPC_IDX_OPCTL, 8'h80);
        repeat (2) @(posedge clk_i);
        chk(oe.rst, 1);
        $display("test bus reset done");
        conclude();
    end
endmodule
`default_nettype wire
